// ==== core/pmd_map.svh ====
// monitor item codes and reset values for the panel monitor selector
`ifndef PMD_MAP_SVH
`define PMD_MAP_SVH

// ************************************************************
// monitor item numbers
// ************************************************************
`define PMD_ITEM_SPEED        5'h00
`define PMD_ITEM_ELEC_ANGLE   5'h01
`define PMD_ITEM_REF_RATE     5'h02
`define PMD_ITEM_BUS_VOLT     5'h03
`define PMD_ITEM_SPEED_REF    5'h04
`define PMD_ITEM_TORQUE_IN    5'h05
`define PMD_ITEM_TORQUE_REF   5'h06
`define PMD_ITEM_INPUT_STATE  5'h07
`define PMD_ITEM_OUTPUT_STATE 5'h08
`define PMD_ITEM_ENC_STATE    5'h09
`define PMD_ITEM_REF_COUNT    5'h0A
`define PMD_ITEM_FB_COUNT     5'h0B
`define PMD_ITEM_POS_OFFSET   5'h0C
`define PMD_ITEM_LOAD_RATIO   5'h0D
`define PMD_ITEM_INERTIA      5'h0E
`define PMD_ITEM_ENC_ANGLE    5'h0F
`define PMD_ITEM_TURN_COUNT   5'h10
`define PMD_ITEM_FIRST        5'h00
`define PMD_ITEM_LAST         5'h10

// ************************************************************
// reset values
// ************************************************************
`define PMD_RST_ITEM          5'h00
`define PMD_RST_COUNT         32'h0000_0000
`define PMD_RST_WORD          16'h0000
`define PMD_RST_SEG           8'h00

`endif

// ==== core/pmd_pkg.sv ====
// types shared by the panel monitor selector
package pmd_pkg;

	// usual path idle -> select -> show, one bit changes per step
	typedef enum logic [1:0] {
		PMD_IDLE   = 2'b00,
		PMD_SELECT = 2'b01,
		PMD_SHOW   = 2'b11
	} pmd_state_t;

	typedef struct packed {
		logic up;
		logic down;
		logic set;
		logic shift;
	} pmd_keys_t;

	// w is bit 0 so that display position one is bit 0
	typedef struct packed {
		logic abc_disc;
		logic a;
		logic b;
		logic c;
		logic uvw_disc;
		logic u;
		logic v;
		logic w;
	} pmd_enc_t;

	typedef struct packed {
		logic pos_mode;
		logic incremental;
		logic multi_turn;
		logic torque_in_amps;
	} pmd_axis_cfg_t;

	typedef struct packed {
		logic [15:0] speed;
		logic [15:0] elec_angle;
		logic [15:0] ref_rate;
		logic [15:0] bus_volt;
		logic [15:0] speed_ref;
		logic [15:0] torque_in_pct;
		logic [15:0] torque_pct;
		logic [15:0] torque_amp;
		logic [15:0] load_ratio;
		logic [15:0] inertia_ratio;
		logic [15:0] turns;
		logic [31:0] ref_pulse_cnt;
		logic [31:0] pos_offset;
		logic [31:0] enc_angle;
	} pmd_axis_vals_t;

	typedef struct packed {
		logic        showing_value;
		logic [4:0]  item;
		logic        axis_b_dp;
		logic        high_half;
		logic        is_wide;
		logic        valid;
		logic        seg_mode;
		logic        unit_amps;
		logic [15:0] word;
		logic [7:0]  seg_upper;
		logic [7:0]  seg_lower;
	} pmd_disp_t;

endpackage

// ==== core/pmd_quad_counter.sv ====
// quadrature feedback pulse counter, one edge of a or b is one count
`timescale 1ns/1ns
`include "pmd_map.svh"
module pmd_quad_counter
	import pmd_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        ce_in,
	input  wire logic        a_in,
	input  wire logic        b_in,
	output logic      [31:0] count_out
);

	logic a_prev;
	logic b_prev;
	logic moved;
	logic up;

	// inputs are already synchronised by the caller
	assign moved = (a_in ^ a_prev) | (b_in ^ b_prev);
	assign up    = a_in ^ b_prev;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			a_prev <= 1'b0;
			b_prev <= 1'b0;
		end else if (ce_in) begin
			a_prev <= a_in;
			b_prev <= b_in;
		end
	end

	// every edge of either phase counts: four counts per line
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count_out <= `PMD_RST_COUNT;
		end else if (ce_in && moved) begin
			if (up) begin
				count_out <= count_out + 32'h0000_0001;
			end else begin
				count_out <= count_out - 32'h0000_0001;
			end
		end
	end

endmodule

// ==== core/pmd_status_segments.sv ====
// maps terminal and encoder states onto upper and lower digit segments
`timescale 1ns/1ns
`include "pmd_map.svh"
module pmd_status_segments
	import pmd_pkg::*;
(
	input  wire logic [4:0] item_in,
	input  wire logic [7:0] in_term_in,
	input  wire logic [5:0] out_term_in,
	input  wire pmd_enc_t   enc_in,
	output logic            seg_mode_out,
	output logic      [7:0] seg_upper_out,
	output logic      [7:0] seg_lower_out
);

	logic [7:0] on_bits;
	logic [7:0] used;

	always_comb begin
		on_bits      = 8'h00;
		used         = 8'h00;
		seg_mode_out = 1'b1;
		unique case (item_in)
			`PMD_ITEM_INPUT_STATE: begin
				on_bits = in_term_in;
				used    = 8'hFF;
			end
			`PMD_ITEM_OUTPUT_STATE: begin
				on_bits = {2'b00, out_term_in};
				used    = 8'h3F;
			end
			`PMD_ITEM_ENC_STATE: begin
				on_bits = enc_in;
				used    = 8'hFF;
			end
			default: begin
				seg_mode_out = 1'b0;
			end
		endcase
	end

	// off lights the upper bar, on lights the lower bar
	assign seg_upper_out = used & ~on_bits;
	assign seg_lower_out = used & on_bits;

endmodule

// ==== core/pmd_monitor.sv ====
// front-panel monitoring mode: item select, axis select, value display
//
// Contract
// - monitor selection never touches motor control
// - seventeen monitor items, fixed units except torque reference
// - pulse rate, reference count, offset need position mode
// - reference, feedback, angle counters are 32-bit
// - feedback counter counts every quadrature edge
// - encoder state valid only with incremental encoder
// - turn count valid only for multi-turn encoder
// - off lights upper segment, on lights lower
// - input positions one to eight are IN1-IN8
// - output positions one to six are OUT1-OUT6
// - encoder positions W,V,U,UVW,C,B,A,ABC in order
// - up/down step item, set shows value
// - digit zero point off for A, on for b
// - set while showing returns to item number
// - torque reference in percent or tenth amperes
// - wide values show low half, shift gives high
`timescale 1ns/1ns
`include "pmd_map.svh"
module pmd_monitor
	import pmd_pkg::*;
(
	input  wire logic           clk_in,
	input  wire logic           nrst_in,
	input  wire logic           ce_in,
	input  wire logic           monitor_mode_in,
	input  wire pmd_keys_t      keys_in,
	input  wire logic     [7:0] in_term_in,
	input  wire logic     [5:0] out_term_in,
	input  wire pmd_enc_t       enc_a_in,
	input  wire pmd_enc_t       enc_b_in,
	input  wire pmd_axis_cfg_t  cfg_a_in,
	input  wire pmd_axis_cfg_t  cfg_b_in,
	input  wire pmd_axis_vals_t vals_a_in,
	input  wire pmd_axis_vals_t vals_b_in,
	output pmd_disp_t           disp_out,
	output logic         [31:0] fb_count_a_out,
	output logic         [31:0] fb_count_b_out
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	pmd_keys_t  keys_s1;
	pmd_keys_t  keys_s2;
	pmd_keys_t  keys_prev;
	logic [7:0] in_s1;
	logic [7:0] in_s2;
	pmd_enc_t   enc_a_s1;
	pmd_enc_t   enc_a_s2;
	pmd_enc_t   enc_b_s1;
	pmd_enc_t   enc_b_s2;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			keys_s1  <= '0;
			keys_s2  <= '0;
			in_s1    <= 8'h00;
			in_s2    <= 8'h00;
			enc_a_s1 <= '0;
			enc_a_s2 <= '0;
			enc_b_s1 <= '0;
			enc_b_s2 <= '0;
		end else if (ce_in) begin
			keys_s1  <= keys_in;
			keys_s2  <= keys_s1;
			in_s1    <= in_term_in;
			in_s2    <= in_s1;
			enc_a_s1 <= enc_a_in;
			enc_a_s2 <= enc_a_s1;
			enc_b_s1 <= enc_b_in;
			enc_b_s2 <= enc_b_s1;
		end
	end

	// ************************************************************
	// key press detection
	// ************************************************************
	logic press_up;
	logic press_down;
	logic press_set;
	logic press_shift;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			keys_prev <= '0;
		end else if (ce_in) begin
			keys_prev <= keys_s2;
		end
	end

	// a key acts once per press, on its rising edge
	assign press_up    = ce_in & keys_s2.up & ~keys_prev.up;
	assign press_down  = ce_in & keys_s2.down & ~keys_prev.down;
	assign press_set   = ce_in & keys_s2.set & ~keys_prev.set;
	assign press_shift = ce_in & keys_s2.shift & ~keys_prev.shift;

	// ************************************************************
	// feedback pulse counters
	// ************************************************************
	pmd_quad_counter u_fb_a (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.ce_in     (ce_in),
		.a_in      (enc_a_s2.a),
		.b_in      (enc_a_s2.b),
		.count_out (fb_count_a_out)
	);

	pmd_quad_counter u_fb_b (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.ce_in     (ce_in),
		.a_in      (enc_b_s2.a),
		.b_in      (enc_b_s2.b),
		.count_out (fb_count_b_out)
	);

	// ************************************************************
	// selection state
	// ************************************************************
	pmd_state_t state;
	pmd_state_t next_state;
	logic [4:0] item;
	logic       axis_b;
	logic       high_half;
	logic       item_wide;

	// the panel only reads drive values; nothing here feeds back
	// into the control loops, so switching is safe while running
	always_comb begin
		next_state = state;
		unique case (state)
			PMD_IDLE: begin
				if (monitor_mode_in) begin
					next_state = PMD_SELECT;
				end
			end
			PMD_SELECT: begin
				if (!monitor_mode_in) begin
					next_state = PMD_IDLE;
				end else if (press_set) begin
					next_state = PMD_SHOW;
				end
			end
			PMD_SHOW: begin
				if (!monitor_mode_in) begin
					next_state = PMD_IDLE;
				end else if (press_set) begin
					next_state = PMD_SELECT;
				end
			end
			default: begin
				next_state = PMD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= PMD_IDLE;
		end else if (ce_in) begin
			state <= next_state;
		end
	end

	// item number persists across mode exits, as a user expects
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			item <= `PMD_RST_ITEM;
		end else if (state == PMD_SELECT && monitor_mode_in) begin
			if (press_up) begin
				if (item == `PMD_ITEM_LAST) begin
					item <= `PMD_ITEM_FIRST;
				end else begin
					item <= item + 5'h01;
				end
			end else if (press_down) begin
				if (item == `PMD_ITEM_FIRST) begin
					item <= `PMD_ITEM_LAST;
				end else begin
					item <= item - 5'h01;
				end
			end
		end
	end

	// each entry to a value starts on axis A and the low half
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			axis_b <= 1'b0;
		end else if (ce_in && state == PMD_SELECT) begin
			axis_b <= 1'b0;
		end else if (state == PMD_SHOW && (press_up || press_down)) begin
			axis_b <= ~axis_b;
		end
	end

	assign item_wide = (item == `PMD_ITEM_REF_COUNT) ||
	                   (item == `PMD_ITEM_FB_COUNT) ||
	                   (item == `PMD_ITEM_ENC_ANGLE);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			high_half <= 1'b0;
		end else if (ce_in && state == PMD_SELECT) begin
			high_half <= 1'b0;
		end else if (state == PMD_SHOW && press_shift && item_wide) begin
			high_half <= ~high_half;
		end
	end

	// ************************************************************
	// value selection
	// ************************************************************
	pmd_axis_vals_t vals;
	pmd_axis_cfg_t  cfg;
	pmd_enc_t       enc_sel;
	logic [31:0]    fb_count;
	logic [31:0]    value;
	logic           valid;
	logic           seg_mode;
	logic [7:0]     seg_upper;
	logic [7:0]     seg_lower;

	assign vals     = axis_b ? vals_b_in : vals_a_in;
	assign cfg      = axis_b ? cfg_b_in : cfg_a_in;
	assign enc_sel  = axis_b ? enc_b_s2 : enc_a_s2;
	assign fb_count = axis_b ? fb_count_b_out : fb_count_a_out;

	always_comb begin
		value = 32'h0000_0000;
		valid = 1'b1;
		unique case (item)
			`PMD_ITEM_SPEED:       value = {16'h0000, vals.speed};
			`PMD_ITEM_ELEC_ANGLE:  value = {16'h0000, vals.elec_angle};
			`PMD_ITEM_REF_RATE: begin
				value = {16'h0000, vals.ref_rate};
				valid = cfg.pos_mode;
			end
			`PMD_ITEM_BUS_VOLT:    value = {16'h0000, vals.bus_volt};
			`PMD_ITEM_SPEED_REF:   value = {16'h0000, vals.speed_ref};
			`PMD_ITEM_TORQUE_IN:   value = {16'h0000, vals.torque_in_pct};
			`PMD_ITEM_TORQUE_REF: begin
				if (cfg.torque_in_amps) begin
					value = {16'h0000, vals.torque_amp};
				end else begin
					value = {16'h0000, vals.torque_pct};
				end
			end
			`PMD_ITEM_INPUT_STATE:  value = 32'h0000_0000;
			`PMD_ITEM_OUTPUT_STATE: value = 32'h0000_0000;
			`PMD_ITEM_ENC_STATE: begin
				valid = cfg.incremental;
			end
			`PMD_ITEM_REF_COUNT: begin
				value = vals.ref_pulse_cnt;
				valid = cfg.pos_mode;
			end
			`PMD_ITEM_FB_COUNT:    value = fb_count;
			`PMD_ITEM_POS_OFFSET: begin
				value = vals.pos_offset;
				valid = cfg.pos_mode;
			end
			`PMD_ITEM_LOAD_RATIO:  value = {16'h0000, vals.load_ratio};
			`PMD_ITEM_INERTIA:     value = {16'h0000, vals.inertia_ratio};
			`PMD_ITEM_ENC_ANGLE:   value = vals.enc_angle;
			`PMD_ITEM_TURN_COUNT: begin
				value = {16'h0000, vals.turns};
				valid = cfg.multi_turn;
			end
			default: begin
				valid = 1'b0;
			end
		endcase
	end

	// input terminals are shared by both axes, so no axis select there
	pmd_status_segments u_seg (
		.item_in       (item),
		.in_term_in    (in_s2),
		.out_term_in   (out_term_in),
		.enc_in        (enc_sel),
		.seg_mode_out  (seg_mode),
		.seg_upper_out (seg_upper),
		.seg_lower_out (seg_lower)
	);

	// ************************************************************
	// display register
	// ************************************************************
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			disp_out <= '0;
		end else if (ce_in) begin
			disp_out.showing_value <= (state == PMD_SHOW);
			disp_out.item          <= item;
			disp_out.axis_b_dp     <= (state == PMD_SHOW) & axis_b;
			// the half flag clears one edge after leaving a value
			disp_out.high_half     <= (state == PMD_SHOW) & high_half;
			disp_out.is_wide       <= item_wide;
			disp_out.valid         <= valid;
			disp_out.seg_mode      <= seg_mode;
			disp_out.unit_amps     <= (item == `PMD_ITEM_TORQUE_REF) &
			                          cfg.torque_in_amps;
			if (state != PMD_SHOW || !valid) begin
				disp_out.word      <= `PMD_RST_WORD;
				disp_out.seg_upper <= `PMD_RST_SEG;
				disp_out.seg_lower <= `PMD_RST_SEG;
			end else begin
				disp_out.word      <= high_half ? value[31:16]
				                                : value[15:0];
				disp_out.seg_upper <= seg_upper;
				disp_out.seg_lower <= seg_lower;
			end
		end
	end

endmodule

// ==== bench/pmd_assertions.sv ====
// concurrent checks on the panel monitor selector ports
`timescale 1ns/1ns
module pmd_assertions
	import pmd_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        nrst_in,
	input wire pmd_enc_t    enc_a_in,
	input wire pmd_disp_t   disp_out,
	input wire logic [31:0] fb_count_a_out
);
	logic [3:0] since;
	logic [4:0] it;
	logic       sv;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	assign it = disp_out.item;
	assign sv = disp_out.showing_value;
	// ************************************************************
	// helper: cycles since the a or b pin last moved
	// ************************************************************
	// a quiet encoder must never move the count, so age the last edge
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			since <= 4'hF;
		else if ($changed(enc_a_in.a) || $changed(enc_a_in.b))
			since <= 4'h0;
		else if (since != 4'hF)
			since <= since + 4'h1;
	end
	// ************************************************************
	// assertions
	// ************************************************************
	item_range_a: assert property (it <= 5'h10)
		else $error("item beyond last");
	seg_disjoint_a: assert property (
		(disp_out.seg_upper & disp_out.seg_lower) == 8'h00)
		else $error("upper and lower segment both lit");
	wide_flag_a: assert property (sv |-> disp_out.is_wide ==
		(it == 5'h0A || it == 5'h0B || it == 5'h0F))
		else $error("wide flag wrong for item");
	half_wide_a: assert property (disp_out.high_half |->
		disp_out.is_wide && sv)
		else $error("high half on narrow value");
	enc_invalid_a: assert property (sv && it == 5'h09 &&
		!disp_out.valid |-> disp_out.word == 16'h0000 &&
		disp_out.seg_upper == 8'h00 && disp_out.seg_lower == 8'h00)
		else $error("invalid encoder state shows data");
	enc_full_a: assert property (sv && disp_out.seg_mode &&
		it == 5'h09 && disp_out.valid |->
		(disp_out.seg_upper ^ disp_out.seg_lower) == 8'hFF)
		else $error("encoder position unlit");
	out_pos_a: assert property (sv && disp_out.seg_mode &&
		it == 5'h08 |->
		(disp_out.seg_upper ^ disp_out.seg_lower) == 8'h3F)
		else $error("output positions wrong");
	select_clear_a: assert property (!sv |->
		disp_out.word == 16'h0000 && !disp_out.high_half &&
		!disp_out.axis_b_dp)
		else $error("number display not clean");
	item_step_a: assert property ($changed(it) |->
		it == (($past(it) == 5'h10) ? 5'h00 : $past(it) + 5'h01) ||
		it == (($past(it) == 5'h00) ? 5'h10 : $past(it) - 5'h01))
		else $error("item jumped");
	fb_step_a: assert property ($changed(fb_count_a_out) |->
		(fb_count_a_out - $past(fb_count_a_out) == 32'h1 ||
		$past(fb_count_a_out) - fb_count_a_out == 32'h1) &&
		since <= 4'h5)
		else $error("feedback count moved wrongly");
	dp_show_a: assert property ($rose(disp_out.axis_b_dp) |->
		$past(sv))
		else $error("axis point outside value display");
	cover property (disp_out.high_half);
	cover property (disp_out.axis_b_dp && sv);
	cover property (sv && it == 5'h09 && disp_out.valid);
endmodule

// ==== bench/pmd_panel_model.sv ====
// keypad model: one press of one key per call
`timescale 1ns/1ns
module pmd_panel_model
	import pmd_pkg::*;
(
	input  wire logic clk_in,
	output pmd_keys_t keys_out
);
	initial keys_out = '0;
	// k: 0 up, 1 down, 2 set, 3 shift; the long gap lets the
	// synchroniser see the release and the display settle
	task press(input int k);
		logic [3:0] v;
		begin
			v = 4'h8 >> k;
			@(posedge clk_in);
			#2 keys_out = v;
			repeat (3) @(posedge clk_in);
			#2 keys_out = '0;
			repeat (6) @(posedge clk_in);
			#2;
		end
	endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking bench of the panel monitor selector
`timescale 1ns/1ns
module testbench;
	import pmd_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, mode = 1'b0;
	logic [7:0] in_t = 8'hA5;
	logic [5:0] out_t = 6'h2D;
	pmd_enc_t enc_a = 8'h95, enc_b = 8'h00;
	pmd_axis_cfg_t cfg_a = 4'hF, cfg_b = 4'h0;
	pmd_axis_vals_t va, vb;
	pmd_keys_t keys;
	pmd_disp_t d;
	logic [31:0] fba, fbb;
	int miscompares = 0, cmp_count = 0;
	always #10 clk = ~clk;
	pmd_panel_model pnl_u (.clk_in(clk), .keys_out(keys));
	pmd_monitor dut_u (.clk_in(clk), .nrst_in(nrst), .ce_in(ce),
		.monitor_mode_in(mode), .keys_in(keys), .in_term_in(in_t),
		.out_term_in(out_t), .enc_a_in(enc_a), .enc_b_in(enc_b),
		.cfg_a_in(cfg_a), .cfg_b_in(cfg_b), .vals_a_in(va),
		.vals_b_in(vb), .disp_out(d), .fb_count_a_out(fba),
		.fb_count_b_out(fbb));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task key(input int k, input int n);
		repeat (n) pnl_u.press(k);
	endtask
	task conclude;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task t_axis;
		key(2, 1);
		cmp("show", 1, d.showing_value);
		cmp("speed a", 32'h3E8, d.word);
		cmp("dp a", 0, d.axis_b_dp);
		key(0, 1);
		cmp("dp b", 1, d.axis_b_dp);
		cmp("speed b", 32'h5DC, d.word);
		key(2, 1);
		cmp("back", 0, d.showing_value);
		cmp("item", 0, d.item);
		$display("test axis done");
	endtask
	task t_wrap;
		key(1, 1);
		cmp("wrap down", 32'h10, d.item);
		key(2, 1);
		cmp("turn valid", 1, d.valid);
		cmp("turns", 32'h7, d.word);
		key(0, 1);
		cmp("turn invalid", 0, d.valid);
		key(2, 1);
		key(0, 1);
		cmp("wrap up", 0, d.item);
		key(1, 1);
		$display("test wrap done");
	endtask
	task t_wide;
		key(1, 1);
		key(2, 1);
		cmp("wide", 1, d.is_wide);
		cmp("low half", 32'h3456, d.word);
		key(3, 1);
		cmp("half", 1, d.high_half);
		cmp("high half", 32'h0012, d.word);
		key(2, 1);
		key(1, 3);
		key(2, 1);
		cmp("pos valid", 1, d.valid);
		cmp("offset", 32'hABC, d.word);
		key(0, 1);
		cmp("pos invalid", 0, d.valid);
		key(2, 1);
		$display("test wide done");
	endtask
	task t_status;
		key(1, 3);
		key(2, 1);
		cmp("enc valid", 1, d.valid);
		cmp("enc low", 32'h95, d.seg_lower);
		cmp("enc up", 32'h6A, d.seg_upper);
		key(0, 1);
		cmp("enc invalid", 0, d.valid);
		key(2, 1);
		key(1, 1);
		key(2, 1);
		cmp("out low", 32'h2D, d.seg_lower);
		cmp("out up", 32'h12, d.seg_upper);
		key(2, 1);
		key(1, 1);
		key(2, 1);
		cmp("in low", 32'hA5, d.seg_lower);
		cmp("in up", 32'h5A, d.seg_upper);
		key(2, 1);
		$display("test status done");
	endtask
	task t_torque;
		key(1, 1);
		key(2, 1);
		cmp("amps", 1, d.unit_amps);
		cmp("amp val", 32'h19, d.word);
		key(0, 1);
		cmp("pct", 0, d.unit_amps);
		cmp("pct val", 32'h50, d.word);
		key(2, 1);
		$display("test torque done");
	endtask
	task t_fb;
		logic [1:0] s[5];
		s = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b01};
		#2;
		for (int i = 0; i < 5; i++) begin
			{enc_a.a, enc_a.b} = s[i];
			repeat (6) @(posedge clk);
			#2;
			if (i == 3)
				cmp("fb up", 32'h4, fba);
		end
		cmp("fb down", 32'h3, fba);
		enc_b.a = 1'b1;
		repeat (6) @(posedge clk);
		#2 cmp("fb b", 32'h1, fbb);
		$display("test feedback done");
	endtask
	initial begin
		va = '0;
		vb = '0;
		va.speed = 16'h03E8;
		va.turns = 16'h0007;
		va.enc_angle = 32'h0012_3456;
		va.pos_offset = 32'h0000_0ABC;
		va.torque_amp = 16'h0019;
		vb.speed = 16'h05DC;
		vb.torque_pct = 16'h0050;
		repeat (8) @(posedge clk);
		#2 nrst = 1'b1;
		@(posedge clk);
		#2 cmp("reset disp", 0, d.showing_value | d.word | d.item);
		mode = 1'b1;
		repeat (3) @(posedge clk);
		t_axis();
		t_wrap();
		t_wide();
		t_status();
		t_torque();
		@(posedge clk);
		t_fb();
		conclude();
	end
	// the scenarios need well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		conclude();
	end
endmodule
bind pmd_monitor pmd_assertions chk_u (.clk_in(clk_in),
	.nrst_in(nrst_in), .enc_a_in(enc_a_in), .disp_out(disp_out),
	.fb_count_a_out(fb_count_a_out));
